// [rtl/bopfm_pkg.sv]
// constants and types of the binary output pfm switch
//
// Behaviour
// - output enable switches pin, default on
// - static mode gives relay level, default
// - static source none disables switching
// - cleaning source follows water/cleaner step
// - limit source ORs chosen eight switches
// - diagnostics: allocated messages or one class
// - analyzer: measurement active or sample needed
// - pfm frequency linear up to 1..1000 Hz
// - pfm source selectable, none gives nothing
// - unipolar plus uses raising part, bipolar both
// - unipolar minus uses lowering part only
// - hold freezes, substitutes or is ignored
// - hold fixed value 0..100 percent, default 0
// - error freezes or fixed percent, default 0
package bopfm_pkg;

   // ==========================================================
   // register map, byte addresses
   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_SEL    = 8'h04;
   localparam logic [7:0] A_FMAX   = 8'h08;
   localparam logic [7:0] A_SUBST  = 8'h0C;
   localparam logic [7:0] A_STATUS = 8'h10;

   // ==========================================================
   // enumerations
   typedef enum logic [2:0] {
      F_NONE = 3'h0, F_LIMIT = 3'h1, F_DIAG = 3'h2,
      F_CLEAN = 3'h3, F_ANA = 3'h4
   } bopfm_func_t;
   typedef enum logic [2:0] {
      S_NONE = 3'h0, S_SENSOR = 3'h1, S_BININ = 3'h2,
      S_CTL = 3'h3, S_FIELDBUS = 3'h4, S_MATH = 3'h5
   } bopfm_src_sel_t;
   typedef enum logic [1:0] {
      A_NONE = 2'h0, A_BIP = 2'h1, A_UPLUS = 2'h2, A_UMINUS = 2'h3
   } bopfm_act_t;
   typedef enum logic [1:0] {
      H_IGNORE = 2'h0, H_FREEZE = 2'h1, H_FIXED = 2'h2
   } bopfm_hold_t;
   typedef enum logic [1:0] {
      N_NONE = 2'h0, N_SAMPLE = 2'h1, N_MEAS = 2'h2
   } bopfm_ana_t;

   // ==========================================================
   // register layouts, lsb last
   typedef struct packed {
      logic           err_frz;  // 1 freeze, 0 fixed value
      bopfm_hold_t    hold_beh;
      bopfm_act_t     act;
      bopfm_src_sel_t pfm_src;
      bopfm_ana_t     ana;
      logic [1:0]     diag_cls; // 0 M, 1 S, 2 C, 3 F
      logic           diag_grp; // 1 whole class
      bopfm_func_t    func;
      logic           pfm;      // 1 pulse frequency mode
      logic           out_en;
   } bopfm_ctrl_t;
   typedef struct packed {
      logic [1:0] clean;        // bit1 cleaner, bit0 water
      logic [7:0] lim_mask;
   } bopfm_sel_t;

   // ==========================================================
   // user-side carriers
   typedef struct packed {
      logic [7:0] limit;
      logic       diag_alloc;
      logic [3:0] diag_cls;
      logic       clean_water;
      logic       clean_cleaner;
      logic       sample_point_one_meas;
      logic       sample_point_one_sample;
      logic       hold;
      logic       error;
   } bopfm_evt_t;
   typedef struct packed {
      logic [15:0]        sensor;
      logic [15:0]        binin;
      logic [15:0]        fieldbus;
      logic [15:0]        math;
      logic signed [15:0] ctl_mv;
   } bopfm_val_t;

   // ==========================================================
   // reset values and ranges
   localparam logic [17:0] CTRL_RST = 18'h00001;
   localparam logic [16:0] FMAX_MIN = 17'h00064; // 1.00 Hz
   localparam logic [16:0] FMAX_MAX = 17'h186A0; // 1000.00 Hz
   localparam logic [6:0]  PCT_MAX  = 7'h64;
   localparam logic [6:0]  PCT_RST  = 7'h00;

   // ==========================================================
   // clock and phase step scale, fmax in 0.01 Hz units
   localparam longint CLK_HZ  = 125_000_000;
   localparam longint STEP_K  = 64'h0001_0000_0000_0000
                                / (CLK_HZ * 100);
   localparam logic [14:0] STEP_KW = 15'(STEP_K);

endpackage // bopfm_pkg

// [rtl/bopfm_subst.sv]
// hold and error substitution of the pfm value
`timescale 1ns/1ps
module bopfm_subst (
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // value and conditions
   input  wire logic [15:0]           value,
   input  wire logic                  hold,
   input  wire logic                  error,
   // behaviour
   input  wire bopfm_pkg::bopfm_hold_t hold_beh,
   input  wire logic                  err_frz,
   input  wire logic [15:0]           hold_frac,
   input  wire logic [15:0]           err_frac,
   // result
   output logic [15:0]                eff
);
   logic [15:0] next_eff;

   // error first, then hold, else live value
   always_comb begin
      next_eff = value;
      if (error) begin
         next_eff = err_frz ? eff : err_frac;
      end else if (hold) begin
         unique case (hold_beh)
            bopfm_pkg::H_FREEZE: next_eff = eff;
            bopfm_pkg::H_FIXED:  next_eff = hold_frac;
            default:             next_eff = value;
         endcase
      end
   end

   // result register doubles as the frozen copy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) eff <= 16'h0000;
      else          eff <= next_eff;
   end

   a_hold_freeze: assert property (@(posedge pclk) disable iff
      (!presetn) hold && !error && hold_beh == bopfm_pkg::H_FREEZE
      |=> $stable(eff)) else $error("hold freeze moved");
   a_err_prio: assert property (@(posedge pclk) disable iff
      (!presetn) error && !err_frz |=> eff == $past(err_frac))
      else $error("error value not applied");
endmodule // bopfm_subst

// [rtl/bopfm_nco.sv]
// phase accumulator making the pfm square wave
`timescale 1ns/1ps
module bopfm_nco #(
   parameter int ACC_W = 32
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // control
   input  wire logic        run,
   input  wire logic [15:0] frac,
   input  wire logic [16:0] fmax,
   // wave
   output logic             wave
);
   logic [47:0]      prod;
   logic [15:0]      inc;
   logic [ACC_W-1:0] acc;
   logic [ACC_W-1:0] next_acc;

   // step proportional to fraction times fmax
   always_comb begin
      prod = 48'(frac) * 48'(fmax) * 48'(bopfm_pkg::STEP_KW);
      inc  = prod[47:32];
      next_acc = run ? acc + ACC_W'(inc) : '0;
   end

   // accumulator and wave from its top bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc  <= '0;
         wave <= 1'b0;
      end else begin
         acc  <= next_acc;
         wave <= next_acc[ACC_W-1];
      end
   end

   a_step_full: assert property (@(posedge pclk) disable iff
      (!presetn) frac == 16'hFFFF && fmax == bopfm_pkg::FMAX_MAX
      |-> inc == 16'h8635) else $error("full scale step wrong");
   a_stop_idle: assert property (@(posedge pclk) disable iff
      (!presetn) !run |=> acc == '0 && !wave)
      else $error("stopped nco not idle");
endmodule // bopfm_nco

// [rtl/bopfm_top.sv]
// binary output channel: static switch or pfm, apb registers
`timescale 1ns/1ps
module bopfm_top (
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   // switching sources and conditions
   input  wire bopfm_pkg::bopfm_evt_t ev,
   // measured values, 16'hFFFF is range upper limit
   input  wire bopfm_pkg::bopfm_val_t val,
   // binary output pin
   output logic                       bo_out
);

   // ==========================================================
   // registers
   bopfm_pkg::bopfm_ctrl_t ctrl;
   bopfm_pkg::bopfm_ctrl_t next_ctrl;
   bopfm_pkg::bopfm_sel_t  sel;
   bopfm_pkg::bopfm_sel_t  next_sel;
   logic [16:0]            fmax;
   logic [16:0]            next_fmax;
   logic [6:0]             hold_pct;
   logic [6:0]             next_hold_pct;
   logic [6:0]             err_pct;
   logic [6:0]             next_err_pct;
   logic [31:0]            next_prdata;
   logic                   next_pready;
   logic                   next_pslverr;
   logic                   next_bo_out;
   logic                   wr;
   logic [31:0]            rd;
   logic                   hit;
   logic [15:0]            eff;
   logic                   wave;

   // percent to fraction of full scale
   function automatic logic [15:0] pct2frac(input logic [6:0] p);
      logic [22:0] w;
      w = 23'(p) * 23'h00FFFF;
      return 16'(w / 23'h000064);
   endfunction

   // clamp a percent write to 100
   function automatic logic [6:0] pclamp(input logic [7:0] p);
      return (p > {1'b0, bopfm_pkg::PCT_MAX}) ? bopfm_pkg::PCT_MAX
                                              : p[6:0];
   endfunction

   // ==========================================================
   // apb decode, zero wait state answer
   always_comb begin
      wr = psel && penable && pready && pwrite;
      hit = 1'b1;
      rd = 32'h0000_0000;
      unique case (paddr)
         bopfm_pkg::A_CTRL:  rd = 32'(ctrl);
         bopfm_pkg::A_SEL:   rd = 32'(sel);
         bopfm_pkg::A_FMAX:  rd = 32'(fmax);
         bopfm_pkg::A_SUBST: rd = {17'h0, err_pct, 1'b0, hold_pct};
         bopfm_pkg::A_STATUS:
            rd = {10'h000, ev.error, ev.hold, eff, 3'h0, bo_out};
         default: hit = 1'b0;
      endcase
      next_pready  = psel && !penable;
      next_prdata  = (psel && !penable && !pwrite) ? rd : prdata;
      next_pslverr = psel && !penable && !hit;
   end

   // register writes, fmax and percents clamped
   always_comb begin
      next_ctrl     = ctrl;
      next_sel      = sel;
      next_fmax     = fmax;
      next_hold_pct = hold_pct;
      next_err_pct  = err_pct;
      if (wr && paddr == bopfm_pkg::A_CTRL) begin
         next_ctrl = bopfm_pkg::bopfm_ctrl_t'(pwdata[17:0]);
      end
      if (wr && paddr == bopfm_pkg::A_SEL) begin
         next_sel = bopfm_pkg::bopfm_sel_t'(pwdata[9:0]);
      end
      if (wr && paddr == bopfm_pkg::A_FMAX) begin
         if (pwdata < 32'(bopfm_pkg::FMAX_MIN)) begin
            next_fmax = bopfm_pkg::FMAX_MIN;
         end else if (pwdata > 32'(bopfm_pkg::FMAX_MAX)) begin
            next_fmax = bopfm_pkg::FMAX_MAX;
         end else begin
            next_fmax = pwdata[16:0];
         end
      end
      if (wr && paddr == bopfm_pkg::A_SUBST) begin
         next_hold_pct = pclamp({1'b0, pwdata[6:0]});
         next_err_pct  = pclamp({1'b0, pwdata[14:8]});
      end
   end

   // register bank and bus answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl     <= bopfm_pkg::bopfm_ctrl_t'(bopfm_pkg::CTRL_RST);
         sel      <= '0;
         fmax     <= bopfm_pkg::FMAX_MAX;
         hold_pct <= bopfm_pkg::PCT_RST;
         err_pct  <= bopfm_pkg::PCT_RST;
         prdata   <= 32'h0000_0000;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
      end else begin
         ctrl     <= next_ctrl;
         sel      <= next_sel;
         fmax     <= next_fmax;
         hold_pct <= next_hold_pct;
         err_pct  <= next_err_pct;
         prdata   <= next_prdata;
         pready   <= next_pready;
         pslverr  <= next_pslverr;
      end
   end

   // ==========================================================
   // static switching level
   logic       st_lvl;
   logic [1:0] cln_req;

   // relay-like level from the chosen source
   always_comb begin
      cln_req = {ev.clean_cleaner, ev.clean_water};
      unique case (ctrl.func)
         bopfm_pkg::F_LIMIT:
            st_lvl = |(ev.limit & sel.lim_mask);
         bopfm_pkg::F_DIAG:
            st_lvl = ctrl.diag_grp ? ev.diag_cls[ctrl.diag_cls]
                                   : ev.diag_alloc;
         bopfm_pkg::F_CLEAN:
            st_lvl = |(cln_req & sel.clean);
         bopfm_pkg::F_ANA: begin
            unique case (ctrl.ana)
               bopfm_pkg::N_SAMPLE:
                  st_lvl = ev.sample_point_one_sample;
               bopfm_pkg::N_MEAS:
                  st_lvl = ev.sample_point_one_meas;
               default: st_lvl = 1'b0;
            endcase
         end
         default: st_lvl = 1'b0;        // none or bad code
      endcase
   end

   // ==========================================================
   // pfm value selection
   logic [15:0] mv_neg;
   logic [15:0] mv_pos;
   logic [15:0] mv_down;
   logic [15:0] raw;

   // controller portion per actuator type
   always_comb begin
      mv_neg  = 16'h0000 - val.ctl_mv;
      mv_pos  = val.ctl_mv[15] ? 16'h0000 : {val.ctl_mv[14:0], 1'b0};
      mv_down = !val.ctl_mv[15] ? 16'h0000 :
                (val.ctl_mv == 16'sh8000) ? 16'hFFFF
                                          : {mv_neg[14:0], 1'b0};
      unique case (ctrl.pfm_src)
         bopfm_pkg::S_SENSOR:   raw = val.sensor;
         bopfm_pkg::S_BININ:    raw = val.binin;
         bopfm_pkg::S_FIELDBUS: raw = val.fieldbus;
         bopfm_pkg::S_MATH:     raw = val.math;
         bopfm_pkg::S_CTL: begin
            unique case (ctrl.act)
               bopfm_pkg::A_BIP:    raw = mv_pos | mv_down;
               bopfm_pkg::A_UPLUS:  raw = mv_pos;
               bopfm_pkg::A_UMINUS: raw = mv_down;
               default:             raw = 16'h0000;
            endcase
         end
         default: raw = 16'h0000;
      endcase
   end

   // hold and error substitution
   bopfm_subst u_subst (
      .pclk      (pclk),
      .presetn   (presetn),
      .value     (raw),
      .hold      (ev.hold),
      .error     (ev.error),
      .hold_beh  (ctrl.hold_beh),
      .err_frz   (ctrl.err_frz),
      .hold_frac (pct2frac(hold_pct)),
      .err_frac  (pct2frac(err_pct)),
      .eff       (eff)
   );

   // frequency generator, idle with no source
   bopfm_nco u_nco (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (ctrl.pfm && ctrl.pfm_src != bopfm_pkg::S_NONE),
      .frac    (eff),
      .fmax    (fmax),
      .wave    (wave)
   );

   // ==========================================================
   // output pin
   always_comb begin
      next_bo_out = ctrl.out_en && (ctrl.pfm ? wave : st_lvl);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) bo_out <= 1'b0;
      else          bo_out <= next_bo_out;
   end

   // ==========================================================
   // checks
   logic stat_on;
   assign stat_on = ctrl.out_en && !ctrl.pfm;

   a_out_off: assert property (@(posedge pclk) disable iff
      (!presetn) !ctrl.out_en |=> !bo_out)
      else $error("disabled output high");
   a_func_none: assert property (@(posedge pclk) disable iff
      (!presetn) !ctrl.pfm && ctrl.func == bopfm_pkg::F_NONE
      |=> !bo_out) else $error("none source drives");
   a_limit_hit: assert property (@(posedge pclk) disable iff
      (!presetn) stat_on && ctrl.func == bopfm_pkg::F_LIMIT
      |=> bo_out == $past(|(ev.limit & sel.lim_mask)))
      else $error("limit level wrong");
   a_clean_lvl: assert property (@(posedge pclk) disable iff
      (!presetn) stat_on && ctrl.func == bopfm_pkg::F_CLEAN
      && sel.clean == 2'h1 |=> bo_out == $past(ev.clean_water))
      else $error("cleaning level wrong");
   a_diag_class: assert property (@(posedge pclk) disable iff
      (!presetn) stat_on && ctrl.func == bopfm_pkg::F_DIAG
      && ctrl.diag_grp |=> bo_out == $past(ev.diag_cls[ctrl.diag_cls]))
      else $error("diag class wrong");
   a_ana_meas: assert property (@(posedge pclk) disable iff
      (!presetn) stat_on && ctrl.func == bopfm_pkg::F_ANA
      && ctrl.ana == bopfm_pkg::N_MEAS
      |=> bo_out == $past(ev.sample_point_one_meas))
      else $error("analyzer level wrong");
   a_uplus_cut: assert property (@(posedge pclk) disable iff
      (!presetn) ctrl.pfm_src == bopfm_pkg::S_CTL
      && ctrl.act == bopfm_pkg::A_UPLUS && val.ctl_mv[15]
      |-> raw == 16'h0000) else $error("uplus passes down");
   a_uminus_cut: assert property (@(posedge pclk) disable iff
      (!presetn) ctrl.pfm_src == bopfm_pkg::S_CTL
      && ctrl.act == bopfm_pkg::A_UMINUS && !val.ctl_mv[15]
      |-> raw == 16'h0000) else $error("uminus passes up");
   a_pfm_none: assert property (@(posedge pclk) disable iff
      (!presetn) (ctrl.pfm && ctrl.pfm_src == bopfm_pkg::S_NONE) [*3]
      |=> !bo_out) else $error("pfm none drives");
   a_hold_fixed: assert property (@(posedge pclk) disable iff
      (!presetn) ev.hold && !ev.error
      && ctrl.hold_beh == bopfm_pkg::H_FIXED
      |=> eff == $past(pct2frac(hold_pct)))
      else $error("hold value wrong");
   a_fmax_range: assert property (@(posedge pclk) disable iff
      (!presetn) fmax >= bopfm_pkg::FMAX_MIN
      && fmax <= bopfm_pkg::FMAX_MAX)
      else $error("fmax out of range");

   c_pfm_toggle: cover property (@(posedge pclk) disable iff
      (!presetn) ctrl.pfm && $rose(bo_out));
   c_limit_on: cover property (@(posedge pclk) disable iff
      (!presetn) ctrl.func == bopfm_pkg::F_LIMIT && $rose(bo_out));
   c_err_hold: cover property (@(posedge pclk) disable iff
      (!presetn) ev.error && ev.hold && ctrl.pfm);

endmodule // bopfm_top

// [verif/bopfm_load.sv]
// load model at the binary output: counts drive strokes
`timescale 1ns/1ps
module bopfm_load (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // driven pin
   input  wire logic        bo_out,
   // strokes seen so far
   output logic [31:0]      pulses
);
   logic last;

   // ==========================================================
   // a pump stroke on each rising edge of the drive
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last   <= 1'b0;
         pulses <= 32'h0;
      end else begin
         last <= bo_out;
         if (bo_out && !last) begin
            pulses <= pulses + 32'h1;
         end
      end
   end
endmodule // bopfm_load

// [verif/bopfm_top_test.sv]
// self-checking bench of the binary output channel
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
   n_errors++; $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module bopfm_top_test;
   // clock, bus, sources and pin
   logic                   pclk = 1'b0;
   logic                   presetn = 1'b0;
   logic                   psel = 1'b0;
   logic                   penable = 1'b0;
   logic                   pwrite = 1'b0;
   logic [7:0]             paddr = 8'h00;
   logic [31:0]            pwdata = 32'h0;
   logic [31:0]            prdata;
   logic                   pready;
   logic                   pslverr;
   bopfm_pkg::bopfm_evt_t  ev = '0;
   bopfm_pkg::bopfm_val_t  val = '0;
   logic                   bo_out;
   logic [31:0]            pulses;
   // bench state
   logic [31:0]            rd;
   logic                   er;
   int                     n_errors = 0;
   int                     checks_done = 0;
   int                     n;
   int                     p;
   logic [15:0]            ev_v [6] = '{16'h0, 16'h1111, 16'h2222,
                                        16'h0, 16'h4444, 16'h5555};
   localparam int HALF = 125_000_000 / 2 / 1000;

   bopfm_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ev(ev), .val(val), .bo_out(bo_out));
   bopfm_load i_load (.pclk(pclk), .presetn(presetn),
      .bo_out(bo_out), .pulses(pulses));

   // clock and reset
   always #4 pclk = ~pclk;

   // ==========================================================
   // verdict and end of run
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // one apb transfer, held until pready is seen high
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 50) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 50) begin
         n_errors++;
         end_of_test();
      end
      // answer taken at the edge where pready is seen high
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask

   // pin level a few cycles after a source change
   task automatic pin(input logic e);
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      `CHK(bo_out, e)
   endtask

   // effective pfm value seen through the status word
   task automatic eff(input logic [15:0] e);
      repeat (3) @(posedge pclk);
      xfer(1'b0, bopfm_pkg::A_STATUS, 32'h0);
      `CHK(rd[31:22], 10'h000)
      `CHK(rd[19:4], e)
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      // reset values and an unmapped place
      rchk(bopfm_pkg::A_CTRL, 32'h00001);
      rchk(bopfm_pkg::A_FMAX, 32'h186A0);
      rchk(bopfm_pkg::A_SUBST, 32'h0);
      xfer(1'b0, 8'h14, 32'h0);
      `CHK({er, rd}, 33'h100000000)
      // full scale at 1000 Hz: first stroke after half a period
      @(posedge pclk) val.sensor <= 16'hFFFF;
      wr(bopfm_pkg::A_CTRL, 32'h403);
      n = 0;
      while (pulses == 0 && n < 70000) begin
         @(posedge pclk);
         n++;
      end
      `CHK(n > HALF - 200 && n < HALF + 200, 1'b1)
      // source none stops the train
      wr(bopfm_pkg::A_CTRL, 32'h003);
      repeat (10) @(posedge pclk);
      p = pulses;
      pin(1'b0);
      repeat (300) @(posedge pclk);
      `CHK(pulses, p)
      // each value source but the controller
      @(posedge pclk) val <= {16'h1111, 16'h2222, 16'h4444, 16'h5555,
                              16'h1000};
      for (int s = 1; s < 6; s++) begin
         if (s != 3) begin
            wr(bopfm_pkg::A_CTRL, 32'h403 + ((s - 1) << 10));
            eff(ev_v[s]);
         end
      end
      // controller portions per actuator type
      wr(bopfm_pkg::A_CTRL, 32'h4C03);
      eff(16'h2000);
      @(posedge pclk) val.ctl_mv <= 16'hF000;
      eff(16'h0000);
      wr(bopfm_pkg::A_CTRL, 32'h6C03);
      eff(16'h2000);
      wr(bopfm_pkg::A_CTRL, 32'h2C03);
      eff(16'h2000);
      // hold and error substitution, hold 50 and error 25 percent
      @(posedge pclk) val.sensor <= 16'h8000;
      wr(bopfm_pkg::A_SUBST, 32'h1932);
      wr(bopfm_pkg::A_CTRL, 32'h403);
      @(posedge pclk) ev.hold <= 1'b1;
      eff(16'h8000);
      wr(bopfm_pkg::A_CTRL, 32'h10403);
      eff(16'h7FFF);
      @(posedge pclk) ev.error <= 1'b1;
      eff(16'h3FFF);
      @(posedge pclk) ev <= '0;
      wr(bopfm_pkg::A_CTRL, 32'h28403);
      eff(16'h8000);
      @(posedge pclk) ev.hold <= 1'b1;
      repeat (3) @(posedge pclk);
      @(posedge pclk) val.sensor <= 16'h1234;
      eff(16'h8000);
      @(posedge pclk) ev.hold <= 1'b0;
      eff(16'h1234);
      @(posedge pclk) ev.error <= 1'b1;
      repeat (3) @(posedge pclk);
      @(posedge pclk) val.sensor <= 16'h4321;
      eff(16'h1234);
      // static: none, limits, output enable
      @(posedge pclk) ev <= '0;
      wr(bopfm_pkg::A_SEL, 32'hFF);
      wr(bopfm_pkg::A_CTRL, 32'h1);
      @(posedge pclk) ev.limit <= 8'hFF;
      pin(1'b0);
      wr(bopfm_pkg::A_SEL, 32'h80);
      wr(bopfm_pkg::A_CTRL, 32'h5);
      pin(1'b1);
      @(posedge pclk) ev.limit <= 8'h7F;
      pin(1'b0);
      @(posedge pclk) ev.limit <= 8'h80;
      pin(1'b1);
      wr(bopfm_pkg::A_CTRL, 32'h4);
      pin(1'b0);
      // diagnostics: allocated, then each class
      wr(bopfm_pkg::A_CTRL, 32'h9);
      @(posedge pclk) ev.diag_alloc <= 1'b1;
      pin(1'b1);
      for (int c = 0; c < 4; c++) begin
         wr(bopfm_pkg::A_CTRL, 32'h29 + (c << 6));
         @(posedge pclk) ev.diag_cls <= 4'h1 << c;
         pin(1'b1);
         @(posedge pclk) ev.diag_cls <= ~(4'h1 << c);
         pin(1'b0);
      end
      // cleaning step assigned to water
      wr(bopfm_pkg::A_SEL, 32'h100);
      wr(bopfm_pkg::A_CTRL, 32'hD);
      @(posedge pclk) ev.clean_cleaner <= 1'b1;
      pin(1'b0);
      @(posedge pclk) ev.clean_water <= 1'b1;
      pin(1'b1);
      // analyzer: sample needed, then measurement active
      wr(bopfm_pkg::A_CTRL, 32'h111);
      @(posedge pclk) ev.sample_point_one_sample <= 1'b1;
      pin(1'b1);
      wr(bopfm_pkg::A_CTRL, 32'h211);
      pin(1'b0);
      @(posedge pclk) ev.sample_point_one_meas <= 1'b1;
      pin(1'b1);
      end_of_test();
   end
endmodule // bopfm_top_test
